// ==== osc_ctrl_consts.svh ====
// Offsets, field positions, reset values and timing counts of the oscillator control block
`ifndef OSC_CTRL_CONSTS_SVH
`define OSC_CTRL_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_OSC_CONTROL 5'h00
`define OFS_CLK_CTRL_FIRST 5'h04
`define OFS_CLK_CTRL_SECOND 5'h08
`define OFS_IRQ_FLAG_FIRST 5'h0C
`define OFS_CPU_STATUS 5'h10
`define OFS_OSC_STATUS 5'h14
`define OFS_IRQ_STATUS 5'h18
`define OFS_IRQ_MASK 5'h1C

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define RANGE_DEFAULT 4'h7
`define RANGE_MID 4'hD
`define RANGE_LOW_EDGE 4'hC
`define RANGE_MAX 4'hF
`define CTRL_FIRST_RESET 8'h87
`define CTRL_SECOND_RESET 8'h00
`define OSC_CONTROL_RESET 8'h60
`define SELM_LSB 6
`define SELS_BIT 3
`define FAULT_BIT 1
`define GEN_OFF_BIT 6
`define VEC_BIT6 6
`define IRQ_W 4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 100
`define STALL_US 20
`define STALL_CYC ((`STALL_US * 1000) / `CLK_NS)
`endif

// ==== osc_ctrl_pkg.sv ====
// Types shared by the oscillator control block
`default_nettype none
package osc_ctrl_pkg;
  typedef enum logic [1:0] {
    OSC_OFF = 2'b00,
    OSC_RUN = 2'b01,
    OSC_STALL = 2'b10,
    OSC_HUNG = 2'b11
  } osc_state_type;
endpackage
`default_nettype wire

// ==== event_flag.sv ====
// One sticky event flag: set wins over clear
`default_nettype none
module event_flag (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic set_evt, // Event pulse
  input wire logic clr, // Clear pulse
  output logic flag // Sticky flag
);
  logic flag_ff;
  logic nxt_flag;

  // Set has priority so an event in the clear cycle survives
  assign nxt_flag = set_evt | (flag_ff & ~clr);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end
  assign flag = flag_ff;
endmodule
`default_nettype wire

// ==== osc_range_clock_ctrl.sv ====
// Oscillator range and clock source control with AXI4-Lite register access
//
// Behaviour
// - Range jump across 12/13 stalls about 20 us
// - Some jumps hang oscillator until power cycle
// - Max range plus step/modulation write stalls
// - Range holds 7 until first control write
// - Oscillator off when no clock uses it
// - Sub-main-only switch does not restart oscillator
// - Main select 00 or 01 starts oscillator
// - Fault flag set forces oscillator on
// - Vector bit 6 sets generator-off at reset
// - Generator-off cuts DC generator when unused
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`default_nettype none
`include "osc_ctrl_consts.svh"
module osc_range_clock_ctrl
  import osc_ctrl_pkg::*;
(
  input wire logic aclk, // Clock, 10 MHz
  input wire logic aresetn, // Sync reset, active low
  input wire logic [15:0] reset_vector, // Fetched reset vector destination
  input wire logic power_cycle, // Pin: supply removed, clears a hang
  input wire logic [4:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [4:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic osc_enable, // Digital oscillator powered
  output logic dc_gen_enable, // Oscillator DC generator on
  output logic digital_osc_clock_ok, // Oscillator delivering clock
  output logic sub_main_clock_stuck, // Sub-main clock held high
  output logic irq // Level interrupt
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] osc_control_reg_ff;
  logic [7:0] basic_clock_ctrl_first_ff;
  logic [7:0] basic_clock_ctrl_second_ff;
  logic osc_fault_flag_ff;
  logic generator_off_bit_ff;
  logic rst_seen_ff;
  logic [3:0] osc_range_applied_ff;
  logic range_touched_ff;
  osc_state_type osc_state_ff;
  osc_state_type nxt_osc_state;
  logic [7:0] stall_cnt_ff;
  logic [7:0] nxt_stall_cnt;
  logic pc_meta_ff;
  logic pc_sync_ff;
  logic [`IRQ_W-1:0] irq_mask_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [4:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic osc_enable_ff;
  logic dc_gen_ff;
  logic clk_ok_ff;
  logic sub_main_clock_stuck_ff;
  logic irq_ff;
  logic [`IRQ_W-1:0] irq_flags;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Address and data taken in either order; both held until the write retires
  wire aw_take = s_axi_awvalid & ~aw_held_ff & ~bvalid_ff;
  wire w_take = s_axi_wvalid & ~w_held_ff & ~bvalid_ff;
  wire wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire [4:0] wr_addr = awaddr_ff;
  wire wr_map = (wr_addr[1:0] == 2'b00) && (wr_addr <= `OFS_IRQ_MASK);
  wire wr_lane = wstrb_ff[0];
  wire wr_ctl = wr_fire & wr_lane & (wr_addr == `OFS_OSC_CONTROL);
  wire wr_bc1 = wr_fire & wr_lane & (wr_addr == `OFS_CLK_CTRL_FIRST);
  wire wr_bc2 = wr_fire & wr_lane & (wr_addr == `OFS_CLK_CTRL_SECOND);
  wire wr_ifg = wr_fire & wr_lane & (wr_addr == `OFS_IRQ_FLAG_FIRST);
  wire wr_sr = wr_fire & wr_lane & (wr_addr == `OFS_CPU_STATUS);
  wire wr_msk = wr_fire & wr_lane & (wr_addr == `OFS_IRQ_MASK);
  wire [7:0] wbyte = wdata_ff[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 5'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Response: OKAY for mapped words, SLVERR for holes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_map ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Reset value of the first control word carries the default range 7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_control_reg_ff <= `OSC_CONTROL_RESET;
      basic_clock_ctrl_first_ff <= `CTRL_FIRST_RESET;
      basic_clock_ctrl_second_ff <= `CTRL_SECOND_RESET;
      irq_mask_ff <= 4'h0;
    end else begin
      if (wr_ctl) begin
        osc_control_reg_ff <= wbyte;
      end
      if (wr_bc1) begin
        basic_clock_ctrl_first_ff <= wbyte;
      end
      if (wr_bc2) begin
        basic_clock_ctrl_second_ff <= wbyte;
      end
      if (wr_msk) begin
        irq_mask_ff <= wbyte[3:0];
      end
    end
  end

  // Fault flag: software writes it directly, hardware never clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_fault_flag_ff <= 1'b0;
    end else if (wr_ifg) begin
      osc_fault_flag_ff <= wbyte[`FAULT_BIT];
    end
  end

  // Generator-off bit caught from the vector one edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_seen_ff <= 1'b0;
      generator_off_bit_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
      if (!rst_seen_ff) begin
        generator_off_bit_ff <= reset_vector[`VEC_BIT6];
      end else if (wr_sr) begin
        generator_off_bit_ff <= wbyte[`GEN_OFF_BIT];
      end
    end
  end

  // ----------------------------------------
  // Oscillator model
  // ----------------------------------------
  // Power-cycle pin is asynchronous: two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_meta_ff <= 1'b0;
      pc_sync_ff <= 1'b0;
    end else begin
      pc_meta_ff <= power_cycle;
      pc_sync_ff <= pc_meta_ff;
    end
  end

  wire [3:0] osc_range_select = basic_clock_ctrl_first_ff[3:0];
  wire [3:0] new_range = wbyte[3:0];
  wire [1:0] main_clock_source_select = basic_clock_ctrl_second_ff[`SELM_LSB+1:`SELM_LSB];
  wire sub_sel_osc = ~basic_clock_ctrl_second_ff[`SELS_BIT];
  wire main_uses_osc = ~main_clock_source_select[1];
  // Sub-main alone never wakes a stopped oscillator, only keeps a running one
  wire osc_wanted = main_uses_osc | osc_fault_flag_ff;
  wire osc_needed = osc_wanted | (sub_sel_osc & (osc_state_ff != OSC_OFF));
  // Range crossing between the low and high bands
  wire old_hi = osc_range_applied_ff > `RANGE_MID;
  wire old_lo = osc_range_applied_ff < `RANGE_LOW_EDGE;
  wire new_hi = new_range > `RANGE_MID;
  wire new_lo = new_range < `RANGE_LOW_EDGE;
  wire range_jump = wr_bc1 & ((old_hi & new_lo) | (old_lo & new_hi));
  // Tuning write while every range bit is set
  wire tune_at_max = wr_ctl & (osc_range_applied_ff == `RANGE_MAX)
    & (wbyte != osc_control_reg_ff);
  // A jump from the very top straight to the bottom is taken as the hanging case
  wire hang_case = range_jump & (osc_range_applied_ff == `RANGE_MAX)
    & (new_range == 4'h0);

  // Applied range follows the register only after the write has retired
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_range_applied_ff <= `RANGE_DEFAULT;
      range_touched_ff <= 1'b0;
    end else begin
      osc_range_applied_ff <= osc_range_select;
      if (wr_bc1) begin
        range_touched_ff <= 1'b1;
      end
    end
  end

  // Next state of the oscillator
  always_comb begin
    nxt_osc_state = osc_state_ff;
    nxt_stall_cnt = stall_cnt_ff;
    case (osc_state_ff)
      OSC_OFF: begin
        if (osc_wanted) begin
          nxt_osc_state = OSC_RUN;
        end
      end
      OSC_RUN: begin
        if (!osc_needed) begin
          nxt_osc_state = OSC_OFF;
        end else if (hang_case) begin
          nxt_osc_state = OSC_HUNG;
        end else if (range_jump | tune_at_max) begin
          nxt_osc_state = OSC_STALL;
          nxt_stall_cnt = 8'(`STALL_CYC - 1);
        end
      end
      OSC_STALL: begin
        if (stall_cnt_ff == 8'h00) begin
          nxt_osc_state = OSC_RUN;
        end else begin
          nxt_stall_cnt = stall_cnt_ff - 8'h01;
        end
      end
      OSC_HUNG: begin
        nxt_osc_state = OSC_HUNG;
      end
      default: begin
        nxt_osc_state = OSC_OFF;
      end
    endcase
  end

  // A hang survives ordinary reset; only a power cycle clears it
  always_ff @(posedge aclk) begin
    if (pc_sync_ff) begin
      osc_state_ff <= OSC_OFF;
      stall_cnt_ff <= 8'h00;
    end else if (!aresetn) begin
      osc_state_ff <= (osc_state_ff == OSC_HUNG) ? OSC_HUNG : OSC_OFF;
      stall_cnt_ff <= 8'h00;
    end else begin
      osc_state_ff <= nxt_osc_state;
      stall_cnt_ff <= nxt_stall_cnt;
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Events: stall start, hang, fault flag raised, sub-main stuck high
  wire rd_take = s_axi_arvalid & ~rvalid_ff;
  wire rd_status = rd_take & (s_axi_araddr == `OFS_IRQ_STATUS);
  wire [`IRQ_W-1:0] irq_events;
  assign irq_events[0] = (osc_state_ff == OSC_RUN) & (nxt_osc_state == OSC_STALL);
  assign irq_events[1] = (osc_state_ff != OSC_HUNG) & (nxt_osc_state == OSC_HUNG);
  assign irq_events[2] = wr_ifg & wbyte[`FAULT_BIT] & ~osc_fault_flag_ff;
  assign irq_events[3] = sub_sel_osc & ~osc_needed & ~sub_main_clock_stuck_ff;

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_W; gi++) begin : g_flag
      event_flag u_flag (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_evt(irq_events[gi]),
        .clr(rd_status),
        .flag(irq_flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  wire rd_map = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= `OFS_IRQ_MASK);
  wire [31:0] osc_status_word = {25'h0000000, range_touched_ff, osc_state_ff,
    osc_range_applied_ff[3:0]} ;
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      `OFS_OSC_CONTROL: rd_mux = {24'h000000, osc_control_reg_ff};
      `OFS_CLK_CTRL_FIRST: rd_mux = {24'h000000, basic_clock_ctrl_first_ff};
      `OFS_CLK_CTRL_SECOND: rd_mux = {24'h000000, basic_clock_ctrl_second_ff};
      `OFS_IRQ_FLAG_FIRST: rd_mux = {30'h00000000, osc_fault_flag_ff, 1'b0};
      `OFS_CPU_STATUS: rd_mux = {25'h0000000, generator_off_bit_ff, 6'h00};
      `OFS_OSC_STATUS: rd_mux = osc_status_word;
      `OFS_IRQ_STATUS: rd_mux = {28'h0000000, irq_flags};
      `OFS_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'b00;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_map ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // DC generator off only when generator-off set and no clock uses the oscillator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_enable_ff <= 1'b0;
      dc_gen_ff <= 1'b0;
      clk_ok_ff <= 1'b0;
      sub_main_clock_stuck_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      osc_enable_ff <= (osc_state_ff != OSC_OFF);
      dc_gen_ff <= ~(generator_off_bit_ff & ~osc_needed);
      clk_ok_ff <= (osc_state_ff == OSC_RUN);
      sub_main_clock_stuck_ff <= sub_sel_osc & ~osc_needed;
      irq_ff <= |(irq_flags & irq_mask_ff);
    end
  end

  assign s_axi_awready = aw_take;
  assign s_axi_wready = w_take;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign osc_enable = osc_enable_ff;
  assign dc_gen_enable = dc_gen_ff;
  assign digital_osc_clock_ok = clk_ok_ff;
  assign sub_main_clock_stuck = sub_main_clock_stuck_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

// ==== osc_range_clock_ctrl_props.sv ====
// Port-level assertions for the oscillator range and clock control block
`default_nettype none
`include "osc_ctrl_consts.svh"
module osc_ctrl_props (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [4:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Address valid
  input wire logic s_axi_awready, // Address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Strobes
  input wire logic s_axi_wvalid, // Data valid
  input wire logic s_axi_wready, // Data ready
  input wire logic s_axi_bvalid, // Response valid
  input wire logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic osc_enable, // Oscillator powered
  input wire logic dc_gen_enable, // DC generator on
  input wire logic digital_osc_clock_ok, // Clock delivered
  input wire logic sub_main_clock_stuck, // Sub-main held high
  input wire logic irq // Interrupt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Write steps
  // ----------------------------------------
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Only a full low-byte write changes a register
  sequence main_to_osc;
    both_taken ##0 s_axi_awaddr == `OFS_CLK_CTRL_SECOND && s_axi_wstrb[0] && !s_axi_wdata[7];
  endsequence
  sequence fault_raised;
    both_taken ##0 s_axi_awaddr == `OFS_IRQ_FLAG_FIRST && s_axi_wstrb[0] && s_axi_wdata[1];
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Both items are held one cycle before the write retires and answers
  a_write_answer: assert property (both_taken |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  a_resp_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken with response pending");
  a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs busy after reset");
  a_main_start: assert property (main_to_osc |-> ##[1:4] osc_enable)
    else $error("main select did not start oscillator");
  a_fault_start: assert property (fault_raised |-> ##[1:4] osc_enable)
    else $error("fault flag did not start oscillator");
  a_ok_needs_power: assert property (digital_osc_clock_ok |-> osc_enable)
    else $error("clock reported while oscillator off");
  a_stuck_clears: assert property (osc_enable [*2] |=> !sub_main_clock_stuck)
    else $error("sub-main stuck while oscillator runs");
  // The enable output lags the state by one cycle, so look one cycle back
  a_dcgen_used: assert property (osc_enable [*4] |-> $past(dc_gen_enable))
    else $error("generator cut while oscillator in use");
endmodule

bind osc_range_clock_ctrl osc_ctrl_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .osc_enable(osc_enable),
  .dc_gen_enable(dc_gen_enable), .digital_osc_clock_ok(digital_osc_clock_ok),
  .sub_main_clock_stuck(sub_main_clock_stuck), .irq(irq)
);
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the oscillator range and clock control block
`default_nettype none
`include "osc_ctrl_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] reset_vector = 16'h0000;
  logic power_cycle = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, osc_en, dc_en, clk_ok, stuck, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0] r;
  logic stall;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 68501;
  int rng, prev;
  int tgt[9] = '{12, 13, 14, 15, 13, 5, 14, 7, 15};

  always #50 aclk = ~aclk;

  osc_range_clock_ctrl u_dut (
    .aclk(aclk), .aresetn(aresetn), .reset_vector(reset_vector), .power_cycle(power_cycle),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_enable(osc_en), .dc_gen_enable(dc_en), .digital_osc_clock_ok(clk_ok),
    .sub_main_clock_stuck(stuck), .irq(irq)
  );

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  // Handshakes are sampled at the falling edge so the rising edge never races the slave
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic ha, hw, hb;
    hb = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      if (hb) chk_reg({30'h0, bresp}, 32'h0);
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q, output logic [1:0] e);
    logic ha, hr;
    hr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      q = rdata;
      e = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] x);
    rd(a, d, r);
    chk_reg(d & {24'h0, m}, {24'h0, x});
  endtask

  // Hang guard: the full run takes about 2700 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rng = $random(seed);
    reset_vector <= rng[15:0];
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    bready <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    rchk(`OFS_OSC_CONTROL, 8'hFF, `OSC_CONTROL_RESET);
    rchk(`OFS_CLK_CTRL_FIRST, 8'hFF, `CTRL_FIRST_RESET);
    rchk(`OFS_CPU_STATUS, 8'hFF, {1'b0, reset_vector[6], 6'h00});
    rchk(`OFS_OSC_STATUS, 8'hFF, 8'h17);
    rd(5'h02, d, r);
    chk_reg({30'h0, r}, 32'h2);
    chk_pin(clk_ok, 1'b1);
    chk_pin(dc_en, 1'b1);
    $display("test reset values done");
    // Range moves, stall expected only across the 12/13 band
    wr(`OFS_IRQ_MASK, 8'h01);
    prev = 7;
    foreach (tgt[i]) begin
      stall = (prev < 12 && tgt[i] > 13) || (prev > 13 && tgt[i] < 12);
      wr(`OFS_CLK_CTRL_FIRST, {4'h8, tgt[i][3:0]});
      repeat (4) @(posedge aclk);
      chk_pin(clk_ok, !stall);
      chk_pin(irq, stall);
      rchk(`OFS_OSC_STATUS, 8'hFF, {2'b01, stall ? 2'b10 : 2'b01, tgt[i][3:0]});
      rchk(`OFS_IRQ_STATUS, 8'h01, {7'h0, stall});
      repeat (170) @(posedge aclk);
      chk_pin(clk_ok, !stall);
      repeat (40) @(posedge aclk);
      chk_pin(clk_ok, 1'b1);
      prev = tgt[i];
    end
    $display("test range moves done");
    // Tuning at top range: a changed value stalls, the same value does not
    wr(`OFS_OSC_CONTROL, 8'h61);
    repeat (4) @(posedge aclk);
    chk_pin(clk_ok, 1'b0);
    rchk(`OFS_IRQ_STATUS, 8'h01, 8'h01);
    repeat (210) @(posedge aclk);
    wr(`OFS_OSC_CONTROL, 8'h61);
    repeat (4) @(posedge aclk);
    chk_pin(clk_ok, 1'b1);
    $display("test tuning done");
    // Hang survives a reset and only a power cycle clears it
    wr(`OFS_CLK_CTRL_FIRST, 8'h80);
    repeat (300) @(posedge aclk);
    rchk(`OFS_OSC_STATUS, 8'h30, 8'h30);
    rng = $random(seed);
    reset_vector <= rng[15:0];
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(`OFS_OSC_STATUS, 8'h30, 8'h30);
    rchk(`OFS_CPU_STATUS, 8'h40, {1'b0, reset_vector[6], 6'h00});
    power_cycle <= 1'b1;
    repeat (8) @(posedge aclk);
    power_cycle <= 1'b0;
    repeat (8) @(posedge aclk);
    chk_pin(clk_ok, 1'b1);
    // Three-step start-up from the default range stays free of stalls
    wr(`OFS_OSC_CONTROL, 8'h00);
    wr(`OFS_CLK_CTRL_FIRST, 8'h8A);
    wr(`OFS_OSC_CONTROL, 8'h61);
    repeat (4) @(posedge aclk);
    chk_pin(clk_ok, 1'b1);
    rchk(`OFS_OSC_STATUS, 8'hFF, 8'h5A);
    $display("test hang done");
    // Every main select code, with sub-main off the oscillator and generator-off set
    wr(`OFS_CPU_STATUS, 8'h40);
    for (int c = 0; c < 4; c++) begin
      wr(`OFS_CLK_CTRL_SECOND, {c[1:0], 6'h08});
      repeat (4) @(posedge aclk);
      chk_pin(osc_en, c < 2);
      chk_pin(dc_en, c < 2);
    end
    wr(`OFS_IRQ_MASK, 8'h08);
    wr(`OFS_CLK_CTRL_SECOND, 8'hC0);
    repeat (4) @(posedge aclk);
    chk_pin(osc_en, 1'b0);
    chk_pin(stuck, 1'b1);
    chk_pin(irq, 1'b1);
    rchk(`OFS_IRQ_STATUS, 8'h08, 8'h08);
    wr(`OFS_IRQ_FLAG_FIRST, 8'h02);
    repeat (4) @(posedge aclk);
    chk_pin(osc_en, 1'b1);
    chk_pin(stuck, 1'b0);
    rchk(`OFS_IRQ_STATUS, 8'h04, 8'h04);
    wr(`OFS_IRQ_FLAG_FIRST, 8'h00);
    repeat (4) @(posedge aclk);
    // Sub-main still draws on the running oscillator, so it stays on
    chk_pin(osc_en, 1'b1);
    wr(`OFS_CLK_CTRL_SECOND, 8'hC8);
    repeat (4) @(posedge aclk);
    chk_pin(osc_en, 1'b0);
    wr(`OFS_CPU_STATUS, 8'h00);
    repeat (4) @(posedge aclk);
    chk_pin(dc_en, 1'b1);
    $display("test clock sources done");
    results();
  end
endmodule
`default_nettype wire
